// ### logic/ibrx_regs.vh
// Register offsets, field positions and constants for the receive manager
`ifndef IBRX_REGS_VH
`define IBRX_REGS_VH
// Register port offsets (word index)
`define IBRX_OFS_MISC_CFG2   4'h0
`define IBRX_OFS_MODE        4'h1
`define IBRX_OFS_INT_CTRL    4'h2
`define IBRX_OFS_INIT_LO     4'h3
`define IBRX_OFS_INIT_HI     4'h4
`define IBRX_OFS_CMD         4'h5
`define IBRX_OFS_STATUS      4'h6
`define IBRX_OFS_DUPLEX      4'h7
// misc_config_two fields
`define IBRX_FULL_DUPLEX_ENABLE_BIT        0
`define IBRX_AUI_FULL_DUPLEX_SELECT_BIT       1
// mode register fields
`define IBRX_MODE_PROM_BIT   15
`define IBRX_MODE_DRCVBC_BIT 14
`define IBRX_MODE_LINK_STATUS_DISABLE_BIT 12
`define IBRX_MODE_INTLOOP_BIT 6
`define IBRX_MODE_RESET      16'h0000
// interrupt control register
`define IBRX_ICR_SPLIT_BIT   5
// command register bits
`define IBRX_CMD_INIT_BIT    0
`define IBRX_CMD_STOP_BIT    1
// init block word indices
`define IBRX_IB_MODE         4'h0
`define IBRX_IB_PADR0        4'h1
`define IBRX_IB_LADRF0       4'h4
`define IBRX_IB_RX_RING_BASE_LO      4'h8
`define IBRX_IB_RX_RING_BASE_HI      4'h9
`define IBRX_IB_TX_RING_BASE_LO      4'ha
`define IBRX_IB_TX_RING_BASE_HI      4'hb
`define IBRX_IB_WORDS        4'hc
// ring length code field
`define IBRX_LEN_MSB         15
`define IBRX_LEN_LSB         13
// receive descriptor word 1 fields
`define IBRX_D1_OWN          15
`define IBRX_D1_ERR          14
`define IBRX_D1_BIT_ALIGNMENT_FAULT         13
`define IBRX_D1_OVERFLOW_FLAG         12
`define IBRX_D1_CRC          11
`define IBRX_D1_CHAIN_MISSING_DESCRIPTOR_FLAG         10
`define IBRX_D1_STP          9
`define IBRX_D1_ENP          8
// Descriptor entry size in bytes, CRC constants
`define IBRX_DESC_BYTES      24'h000008
`define IBRX_CRC_POLY        32'h04c11db7
`define IBRX_CRC_INIT        32'hffffffff
// Port select codes
`define IBRX_PORT_AUI        2'h0
`define IBRX_PORT_TP         2'h1
`define IBRX_PORT_GENERAL_SERIAL_PORT       2'h2
`endif

// ### logic/ibrx_core.v
// Init block loader, address filter and receive descriptor manager
// How it works
// R1 - Duplex follows enable bit; AUI port also needs its duplex select bit
// R2 - Twisted-pair full duplex blocked while link status disable is set
// R3 - Enable bit always read/write, cleared only by hardware reset
// R4 - Host places init block on a 16-bit boundary
// R5 - Init block is twelve 16-bit words in fixed order
// R6 - Ring length code is bits 15..13; ring has 2^code entries
// R7 - Host aligns descriptor entries to 8 bytes from ring base
// R8 - First wire bit one means logical, else compare node address
// R9 - Logical address: CRC top six bits pick one hash mask bit
// R10 - All-zero mask without promiscuous rejects every logical but broadcast
// R11 - Broadcast bypasses mask; disable bit rejects unless promiscuous
// R12 - Host hands FCS to receiver for multicast external loopback
// R13 - Node address 48 bits, byte n in lane n, bit 0 zero
// R14 - Init copies mode word into mode register
// R15 - Buffer address is word0 low plus word1 bits 7..0 high
// R16 - Own bit 15: device clears after fill, host sets after empty
// R17 - Error bit 14 is OR of framing, overflow, CRC, buffer flags
// R18 - Framing flag only with odd bits and FCS fail, not loopback
// R19 - Overflow flag set when FIFO overflows and data is lost
// R20 - CRC flag set when frame fails FCS
// R21 - Buffer flag when next buffer missing; overflow only if coincident
// R22 - First buffer gets start flag, last gets end flag; with the split bit set the start flag is copied from the descriptor instead
// R23 - Read own bit before data; status and own cleared together after
// R24 - AUI duplex select only matters with enable; reset clears it
module ibrx_core #(
	parameter DATA_W = 16
)(
	input  wire              clock,
	input  wire              sys_rst,
	input  wire [3:0]        reg_addr,
	input  wire [15:0]       reg_wdata,
	input  wire              reg_wr,
	input  wire              reg_rd,
	output reg  [15:0]       reg_rdata,
	input  wire [1:0]        port_sel,
	output wire              full_duplex,
	output reg               mem_req,
	output reg               mem_we,
	output reg  [23:0]       mem_addr,
	output reg  [15:0]       mem_wdata,
	input  wire              mem_ack,
	input  wire [15:0]       mem_rdata,
	input  wire              rx_addr_valid,
	input  wire [47:0]       rx_dest_addr,
	output reg               rx_accept,
	input  wire              rx_start,
	input  wire              rx_buf_full,
	input  wire              rx_end,
	input  wire              rx_fifo_ovf,
	input  wire              rx_fcs_bad,
	input  wire              rx_dribble,
	output wire              rx_ready,
	output reg  [23:0]       rx_buf_addr,
	output reg               rx_done
);
`include "ibrx_regs.vh"
	localparam ST_IDLE  = 3'h0;
	localparam ST_INIT  = 3'h1;
	localparam ST_POLL  = 3'h2;
	localparam ST_POLL2 = 3'h3;
	localparam ST_FILL  = 3'h4;
	localparam ST_WST   = 3'h5;
	localparam ST_NEXT  = 3'h6;
	localparam ST_NEXT2 = 3'h7;

	reg  [1:0]  misc_q;
	reg  [15:0] mode_q;
	reg  [15:0] icr_q;
	reg  [23:0] init_base_q;
	reg  [47:0] node_q;
	reg  [63:0] hash_q;
	reg  [23:0] rx_ring_q;
	reg  [2:0]  rx_len_q;
	reg  [23:0] tx_ring_q;
	reg  [2:0]  tx_len_q;
	reg  [2:0]  st_q;
	reg  [3:0]  ib_idx_q;
	reg  [6:0]  rx_idx_q;
	reg  [15:0] d0_q;
	reg  [7:0]  address_high_byte_q;
	reg         first_q;
	reg         started_q;
	reg         chain_missing_descriptor_flag_q;
	reg         overflow_flag_q;
	reg         eof_q;
	reg         bit_alignment_fault_q;
	reg         crcf_q;
	reg         init_done_q;

	// R1 duplex select
	// R2 link-status gate
	// R24 AUI select gated by enable
	assign full_duplex = misc_q[`IBRX_FULL_DUPLEX_ENABLE_BIT] &
		((port_sel == `IBRX_PORT_AUI) ? misc_q[`IBRX_AUI_FULL_DUPLEX_SELECT_BIT] :
		 (port_sel == `IBRX_PORT_TP) ? ~mode_q[`IBRX_MODE_LINK_STATUS_DISABLE_BIT] :
		 1'b1);

	assign rx_ready = (st_q == ST_FILL);

	// Ring slot address, entry index masked by 2^code - 1
	wire [6:0]  len_mask = (7'h01 << rx_len_q) - 7'h01;
	wire [6:0]  idx_next = (rx_idx_q + 7'h01) & len_mask;
	wire [23:0] desc_addr = rx_ring_q + {14'h0000, rx_idx_q, 3'h0};

	// Hash CRC over the 48 address bits, wire order is bit 0 first
	function [31:0] crc48;
		input [47:0] a;
		integer      i;
		reg   [31:0] c;
		begin
			c = `IBRX_CRC_INIT;
			for (i = 0; i < 48; i = i + 1)
				c = {c[30:0], 1'b0} ^
					((c[31] ^ a[i]) ? `IBRX_CRC_POLY : 32'h00000000);
			crc48 = c;
		end
	endfunction

	wire [31:0] hash_crc = crc48(rx_dest_addr);
	wire        is_bcast = &rx_dest_addr;
	wire        prom     = mode_q[`IBRX_MODE_PROM_BIT];

	// R8 logical versus physical
	// R9 hash filter pick
	// R10 zero mask rejects
	// R11 broadcast handling
	always @(posedge clock)
	begin
		if (sys_rst)
			rx_accept <= 1'b0;
		else if (rx_addr_valid)
		begin
			if (prom)
				rx_accept <= 1'b1;
			else if (is_bcast)
				rx_accept <= ~mode_q[`IBRX_MODE_DRCVBC_BIT];
			else if (rx_dest_addr[0])
				rx_accept <= hash_q[hash_crc[31:26]];
			else
				rx_accept <= (rx_dest_addr == node_q);
		end
	end

	// Status word: error flags, ownership cleared
	wire        bit_alignment_fault_v = bit_alignment_fault_q & ~mode_q[`IBRX_MODE_INTLOOP_BIT];
	wire [15:0] status_w;
	// R17 error summary
	assign status_w[`IBRX_D1_ERR]  = bit_alignment_fault_v | overflow_flag_q | crcf_q | chain_missing_descriptor_flag_q;
	assign status_w[`IBRX_D1_OWN]  = 1'b0;
	assign status_w[`IBRX_D1_BIT_ALIGNMENT_FAULT] = bit_alignment_fault_v;
	assign status_w[`IBRX_D1_OVERFLOW_FLAG] = overflow_flag_q;
	assign status_w[`IBRX_D1_CRC]  = crcf_q;
	assign status_w[`IBRX_D1_CHAIN_MISSING_DESCRIPTOR_FLAG] = chain_missing_descriptor_flag_q;
	// R22 start and end marks
	assign status_w[`IBRX_D1_STP]  =
		icr_q[`IBRX_ICR_SPLIT_BIT] ? mem_rdata[`IBRX_D1_STP] : first_q;
	assign status_w[`IBRX_D1_ENP]  = eof_q;
	assign status_w[7:0]           = address_high_byte_q;

	always @(posedge clock)
	begin
		if (sys_rst)
		begin
			// R3 reset clears enable
			misc_q      <= 2'h0;
			mode_q      <= `IBRX_MODE_RESET;
			icr_q       <= 16'h0000;
			init_base_q <= 24'h000000;
			node_q      <= 48'h0;
			hash_q      <= 64'h0;
			rx_ring_q   <= 24'h000000;
			rx_len_q    <= 3'h0;
			tx_ring_q   <= 24'h000000;
			tx_len_q    <= 3'h0;
			st_q        <= ST_IDLE;
			ib_idx_q    <= 4'h0;
			rx_idx_q    <= 7'h00;
			d0_q        <= 16'h0000;
			address_high_byte_q      <= 8'h00;
			first_q     <= 1'b1;
			started_q   <= 1'b0;
			chain_missing_descriptor_flag_q      <= 1'b0;
			overflow_flag_q      <= 1'b0;
			eof_q       <= 1'b0;
			bit_alignment_fault_q      <= 1'b0;
			crcf_q      <= 1'b0;
			init_done_q <= 1'b0;
			mem_req     <= 1'b0;
			mem_we      <= 1'b0;
			mem_addr    <= 24'h000000;
			mem_wdata   <= 16'h0000;
			rx_buf_addr <= 24'h000000;
			rx_done     <= 1'b0;
		end
		else
		begin
			rx_done <= 1'b0;
			if (reg_wr)
			begin
				case (reg_addr)
				// R3 always writable, stop leaves it alone
				`IBRX_OFS_MISC_CFG2: misc_q <= reg_wdata[1:0];
				`IBRX_OFS_MODE:      mode_q <= reg_wdata;
				`IBRX_OFS_INT_CTRL:  icr_q <= reg_wdata;
				`IBRX_OFS_INIT_LO:   init_base_q[15:0] <= reg_wdata;
				`IBRX_OFS_INIT_HI:   init_base_q[23:16] <= reg_wdata[7:0];
				default: ;
				endcase
			end
			if (reg_wr && reg_addr == `IBRX_OFS_CMD &&
				reg_wdata[`IBRX_CMD_STOP_BIT])
			begin
				st_q        <= ST_IDLE;
				mem_req     <= 1'b0;
				init_done_q <= 1'b0;
			end
			else
			begin
				case (st_q)
				ST_IDLE:
				begin
					if (reg_wr && reg_addr == `IBRX_OFS_CMD &&
						reg_wdata[`IBRX_CMD_INIT_BIT])
					begin
						st_q     <= ST_INIT;
						ib_idx_q <= 4'h0;
						mem_req  <= 1'b1;
						mem_we   <= 1'b0;
						// R4 block base word aligned
						mem_addr <= {init_base_q[23:1], 1'b0};
					end
					else if (init_done_q)
					begin
						st_q <= ST_POLL;
						mem_req <= 1'b1;
						mem_we <= 1'b0;
						mem_addr <= desc_addr + 24'h000002;
					end
				end
				// R5 twelve words read in order
				ST_INIT:
				begin
					if (mem_ack)
					begin
						case (ib_idx_q)
						// R14 mode copied to register
						`IBRX_IB_MODE: mode_q <= mem_rdata;
						// R13 byte lanes in order
						4'h1: node_q[15:0]  <= mem_rdata;
						4'h2: node_q[31:16] <= mem_rdata;
						4'h3: node_q[47:32] <= mem_rdata;
						4'h4: hash_q[15:0]  <= mem_rdata;
						4'h5: hash_q[31:16] <= mem_rdata;
						4'h6: hash_q[47:32] <= mem_rdata;
						4'h7: hash_q[63:48] <= mem_rdata;
						`IBRX_IB_RX_RING_BASE_LO: rx_ring_q[15:0] <= mem_rdata;
						// R6 length code field
						`IBRX_IB_RX_RING_BASE_HI:
						begin
							rx_ring_q[23:16] <= mem_rdata[7:0];
							rx_len_q <= mem_rdata[`IBRX_LEN_MSB:`IBRX_LEN_LSB];
						end
						`IBRX_IB_TX_RING_BASE_LO: tx_ring_q[15:0] <= mem_rdata;
						default:
						begin
							tx_ring_q[23:16] <= mem_rdata[7:0];
							tx_len_q <= mem_rdata[`IBRX_LEN_MSB:`IBRX_LEN_LSB];
						end
						endcase
						if (ib_idx_q == `IBRX_IB_WORDS - 4'h1)
						begin
							mem_req     <= 1'b0;
							init_done_q <= 1'b1;
							rx_idx_q    <= 7'h00;
							st_q        <= ST_IDLE;
						end
						else
						begin
							ib_idx_q <= ib_idx_q + 4'h1;
							mem_addr <= mem_addr + 24'h000002;
						end
					end
				end
				// R23 own bit read before any data
				ST_POLL:
				begin
					if (mem_ack)
					begin
						if (mem_rdata[`IBRX_D1_OWN])
						begin
							address_high_byte_q   <= mem_rdata[7:0];
							mem_addr <= desc_addr;
							st_q     <= ST_POLL2;
						end
						else
							mem_req <= 1'b0;
					end
					else if (!mem_req)
						mem_req <= 1'b1;
				end
				ST_POLL2:
				begin
					if (mem_ack)
					begin
						d0_q    <= mem_rdata;
						mem_req <= 1'b0;
						// R15 24-bit buffer address
						rx_buf_addr <= {address_high_byte_q, mem_rdata};
						st_q    <= ST_FILL;
					end
				end
				ST_FILL:
				begin
					if (rx_start)
						started_q <= 1'b1;
					// R19 overflow flag
					if (rx_fifo_ovf)
						overflow_flag_q <= 1'b1;
					if (rx_end || rx_buf_full || rx_fifo_ovf)
					begin
						eof_q  <= rx_end & ~rx_fifo_ovf;
						// R20 CRC flag
						crcf_q <= rx_end & rx_fcs_bad & ~rx_fifo_ovf;
						// R18 framing flag
						bit_alignment_fault_q <= rx_end & rx_fcs_bad & rx_dribble &
							~rx_fifo_ovf;
						// Chaining waits for the next slot address
						mem_req   <= rx_end | ~rx_buf_full | rx_fifo_ovf;
						mem_we    <= 1'b0;
						mem_addr  <= desc_addr + 24'h000002;
						st_q      <= (rx_buf_full && !rx_end &&
							!rx_fifo_ovf) ? ST_NEXT : ST_WST;
					end
				end
				// R21 chaining needs next buffer
				ST_NEXT:
				begin
					mem_addr <= rx_ring_q + {14'h0000, idx_next, 3'h0} +
						24'h000002;
					mem_req <= 1'b1;
					st_q <= ST_NEXT2;
				end
				ST_NEXT2:
				begin
					if (mem_ack)
					begin
						if (!mem_rdata[`IBRX_D1_OWN])
							chain_missing_descriptor_flag_q <= 1'b1;
						if (rx_fifo_ovf)
						begin
							chain_missing_descriptor_flag_q <= 1'b1;
							overflow_flag_q <= 1'b1;
						end
						mem_addr <= desc_addr + 24'h000002;
						st_q     <= ST_WST;
					end
					else if (rx_fifo_ovf)
						chain_missing_descriptor_flag_q <= 1'b1;
				end
				// R16 own cleared after fill
				// R23 status and own in one write
				ST_WST:
				begin
					if (mem_ack && !mem_we)
					begin
						mem_we    <= 1'b1;
						mem_wdata <= status_w;
					end
					else if (mem_ack && mem_we)
					begin
						mem_req   <= 1'b0;
						mem_we    <= 1'b0;
						rx_done   <= 1'b1;
						rx_idx_q  <= idx_next;
						first_q   <= eof_q | overflow_flag_q | chain_missing_descriptor_flag_q;
						chain_missing_descriptor_flag_q    <= 1'b0;
						overflow_flag_q    <= 1'b0;
						eof_q     <= 1'b0;
						bit_alignment_fault_q    <= 1'b0;
						crcf_q    <= 1'b0;
						started_q <= 1'b0;
						st_q      <= ST_IDLE;
					end
				end
				default: st_q <= ST_IDLE;
				endcase
			end
		end
	end

	// Register read port, data one cycle after the strobe
	always @(posedge clock)
	begin
		if (sys_rst)
			reg_rdata <= 16'h0000;
		else if (reg_rd)
		begin
			case (reg_addr)
			`IBRX_OFS_MISC_CFG2: reg_rdata <= {14'h0000, misc_q};
			`IBRX_OFS_MODE:      reg_rdata <= mode_q;
			`IBRX_OFS_INT_CTRL:  reg_rdata <= icr_q;
			`IBRX_OFS_INIT_LO:   reg_rdata <= init_base_q[15:0];
			`IBRX_OFS_INIT_HI:   reg_rdata <= {8'h00, init_base_q[23:16]};
			`IBRX_OFS_STATUS:
				reg_rdata <= {init_done_q, 4'h0, st_q, 1'b0, rx_idx_q};
			`IBRX_OFS_DUPLEX:    reg_rdata <= {15'h0000, full_duplex};
			default:             reg_rdata <= 16'h0000;
			endcase
		end
	end
endmodule // ibrx_core

// ### testbench/ibrx_mem.sv
// Host memory model holding the init block and the receive ring
module ibrx_mem (
	input  logic        clock,
	input  logic        mem_req,
	input  logic        mem_we,
	input  logic [23:0] mem_addr,
	input  logic [15:0] mem_wdata,
	input  logic        slow,
	output logic        mem_ack,
	output logic [15:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:63];
	logic        wait_q;
	initial
	begin
		mem_ack = 1'b0;
		mem_rdata = 16'h0000;
		wait_q = 1'b0;
	end
	// word store answers promptly or slowly
	always @(posedge clock)
	begin
		mem_rdata <= ~mem_rdata;
		mem_ack <= 1'b0;
		wait_q <= 1'b0;
		if (mem_req && !mem_ack && slow && !wait_q)
			wait_q <= 1'b1;
		else if (mem_req && !mem_ack)
		begin
			mem_ack <= 1'b1;
			if (mem_we)
				mem[mem_addr[6:1]] <= mem_wdata;
			else
				mem_rdata <= mem[mem_addr[6:1]];
		end
	end
endmodule // ibrx_mem

// ### testbench/ibrx_core_chk.sv
// Port assertions for the receive manager
module ibrx_chk (
	input logic        clock,
	input logic        sys_rst,
	input logic [3:0]  reg_addr,
	input logic [15:0] reg_wdata,
	input logic        reg_wr,
	input logic        reg_rd,
	input logic [15:0] reg_rdata,
	input logic [1:0]  port_sel,
	input logic        full_duplex,
	input logic        mem_req,
	input logic        mem_we,
	input logic [23:0] mem_addr,
	input logic [15:0] mem_wdata,
	input logic        mem_ack,
	input logic        rx_done
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	a_fd_off: assert property (reg_wr && reg_addr == 4'h0 && !reg_wdata[0]
		|=> !full_duplex) else $error("full duplex with enable clear");
	a_fd_aui: assert property (reg_wr && reg_addr == 4'h0
		&& reg_wdata[1:0] == 2'b01 ##1 port_sel == 2'h0 |-> !full_duplex)
		else $error("aui full duplex without select");
	a_fd_general_serial_port: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[0]
		&& port_sel[1] ##1 port_sel[1] |-> full_duplex)
		else $error("serial port not full duplex");
	a_cfg_rdback: assert property (reg_wr && reg_addr == 4'h0
		##2 reg_rd && reg_addr == 4'h0
		|=> reg_rdata[1:0] == $past(reg_wdata[1:0], 3))
		else $error("config readback wrong");
	a_rst_clear: assert property ($fell(sys_rst)
		|-> !full_duplex && !mem_req && !rx_done)
		else $error("state not cleared by reset");
	a_own_clear: assert property (mem_req && mem_we |-> !mem_wdata[15])
		else $error("status write keeps ownership");
	a_err_or: assert property (mem_req && mem_we
		|-> mem_wdata[14] == |mem_wdata[13:10])
		else $error("error summary wrong");
	a_done_ack: assert property (rx_done
		|-> $past(mem_req && mem_we && mem_ack))
		else $error("done without status write");
	a_addr_even: assert property (mem_req |-> !mem_addr[0])
		else $error("odd memory address");
	a_req_hold: assert property (mem_req && !mem_ack
		|=> mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("memory request changed before ack");
endmodule // ibrx_chk

bind ibrx_core ibrx_chk chk_i (
	.clock       (clock),
	.sys_rst     (sys_rst),
	.reg_addr    (reg_addr),
	.reg_wdata   (reg_wdata),
	.reg_wr      (reg_wr),
	.reg_rd      (reg_rd),
	.reg_rdata   (reg_rdata),
	.port_sel    (port_sel),
	.full_duplex (full_duplex),
	.mem_req     (mem_req),
	.mem_we      (mem_we),
	.mem_addr    (mem_addr),
	.mem_wdata   (mem_wdata),
	.mem_ack     (mem_ack),
	.rx_done     (rx_done)
);

// ### testbench/tb_ibrx_core.sv
// Self-checking bench for the receive manager
module tb_ibrx_core;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, sys_rst, reg_wr, reg_rd, full_duplex, slow;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, mem_wdata, mem_rdata;
	logic [1:0]  port_sel;
	logic        mem_req, mem_we, mem_ack, rx_addr_valid, rx_accept;
	logic [23:0] mem_addr, rx_buf_addr;
	logic [47:0] rx_dest_addr;
	logic        rx_start, rx_buf_full, rx_end, rx_fifo_ovf, rx_fcs_bad;
	logic        rx_dribble, rx_ready, rx_done;
	int          failures, samples_checked, cyc;
	logic [5:0]  k;

	ibrx_core ibrx_core_i (
		.clock         (clock),
		.sys_rst       (sys_rst),
		.reg_addr      (reg_addr),
		.reg_wdata     (reg_wdata),
		.reg_wr        (reg_wr),
		.reg_rd        (reg_rd),
		.reg_rdata     (reg_rdata),
		.port_sel      (port_sel),
		.full_duplex   (full_duplex),
		.mem_req       (mem_req),
		.mem_we        (mem_we),
		.mem_addr      (mem_addr),
		.mem_wdata     (mem_wdata),
		.mem_ack       (mem_ack),
		.mem_rdata     (mem_rdata),
		.rx_addr_valid (rx_addr_valid),
		.rx_dest_addr  (rx_dest_addr),
		.rx_accept     (rx_accept),
		.rx_start      (rx_start),
		.rx_buf_full   (rx_buf_full),
		.rx_end        (rx_end),
		.rx_fifo_ovf   (rx_fifo_ovf),
		.rx_fcs_bad    (rx_fcs_bad),
		.rx_dribble    (rx_dribble),
		.rx_ready      (rx_ready),
		.rx_buf_addr   (rx_buf_addr),
		.rx_done       (rx_done)
	);
	ibrx_mem ibrx_mem_i (
		.clock     (clock),
		.mem_req   (mem_req),
		.mem_we    (mem_we),
		.mem_addr  (mem_addr),
		.mem_wdata (mem_wdata),
		.slow      (slow),
		.mem_ack   (mem_ack),
		.mem_rdata (mem_rdata)
	);

	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			end_sim;
		end
	end

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	// Filter bit pick: CRC-32 of the address sent bit 0 first, top six bits
	function automatic logic [5:0] hpick(input logic [47:0] a);
		logic [31:0] c;
		c = 32'hffffffff;
		for (int i = 0; i < 48; i++)
			c = {c[30:0], 1'b0} ^
				((c[31] ^ a[i]) ? 32'h04c11db7 : 32'h00000000);
		return c[31:26];
	endfunction

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask

	// Waits for buffer ready (w=0) or frame done (w=1)
	task automatic wt(input logic w);
		for (int i = 0; i < 300 && (w ? rx_done : rx_ready) !== 1'b1; i++)
		begin
			@(posedge clock);
			#1;
		end
	endtask

	task automatic dst(input logic [47:0] a, input logic e);
		@(posedge clock);
		rx_addr_valid <= 1'b1;
		rx_dest_addr <= a;
		@(posedge clock);
		rx_addr_valid <= 1'b0;
		@(posedge clock);
		#1 chk(rx_accept, e);
	endtask

	// Event bits: end, dribble, fcs bad, buffer full, fifo overflow
	task automatic frame(input logic [4:0] ev, input logic [15:0] e);
		ibrx_mem_i.mem[33] = 16'h8056;
		wt(1'b0);
		chk(rx_buf_addr, 48'h561234);
		@(posedge clock);
		rx_start <= 1'b1;
		@(posedge clock);
		rx_start <= 1'b0;
		@(posedge clock);
		{rx_end, rx_dribble, rx_fcs_bad} <= ev[4:2];
		{rx_buf_full, rx_fifo_ovf} <= ev[1:0];
		@(posedge clock);
		{rx_end, rx_dribble, rx_fcs_bad} <= 3'h0;
		{rx_buf_full, rx_fifo_ovf} <= 2'h0;
		wt(1'b1);
		chk(rx_done, 1'b1);
		chk(ibrx_mem_i.mem[33], e);
	endtask

	initial
	begin
		{reg_wr, reg_rd, reg_addr, reg_wdata, port_sel, slow} = '0;
		{rx_addr_valid, rx_dest_addr, rx_start, rx_buf_full} = '0;
		{rx_end, rx_fifo_ovf, rx_fcs_bad, rx_dribble} = '0;
		sys_rst = 1'b1;
		foreach (ibrx_mem_i.mem[i])
			ibrx_mem_i.mem[i] = 16'h0000;
		// no external loopback here, so FCS needs no hand-over
		ibrx_mem_i.mem[8] = 16'h4000;
		ibrx_mem_i.mem[9] = 16'h2210;
		ibrx_mem_i.mem[10] = 16'h4433;
		ibrx_mem_i.mem[11] = 16'h6655;
		ibrx_mem_i.mem[16] = 16'h0040;
		ibrx_mem_i.mem[32] = 16'h1234;
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		rd(4'h0, 16'h0000);
		for (int m = 0; m < 4; m++)
			for (int dl = 0; dl < 2; dl++)
			begin
				wr(4'h0, 16'(m));
				wr(4'h1, dl ? 16'h1000 : 16'h0000);
				for (int p = 0; p < 4; p++)
				begin
					port_sel <= 2'(p);
					@(posedge clock);
					#1 chk(full_duplex, m[0] && (p == 0 ? m[1] : p != 1 || !dl));
				end
			end
		rd(4'h0, 16'h0003);
		wr(4'h5, 16'h0002);
		rd(4'h0, 16'h0003);
		wr(4'h1, 16'h0000);
		$display("duplex test done");
		wr(4'h3, 16'h0010);
		wr(4'h4, 16'h0000);
		wr(4'h5, 16'h0001);
		frame(5'h14, 16'h4b56);
		rd(4'h1, 16'h4000);
		slow = 1'b1;
		frame(5'h1c, 16'h6b56);
		frame(5'h18, 16'h0356);
		frame(5'h02, 16'h0256);
		frame(5'h10, 16'h0156);
		frame(5'h01, 16'h5256);
		$display("descriptor test done");
		dst(48'h665544332210, 1'b1);
		dst(48'h665544332212, 1'b0);
		dst(48'h665544332211, 1'b0);
		dst(48'hffffffffffff, 1'b0);
		wr(4'h1, 16'hc000);
		dst(48'hffffffffffff, 1'b1);
		wr(4'h1, 16'h0000);
		dst(48'hffffffffffff, 1'b1);
		$display("filter test done");
		port_sel <= 2'h0;
		wr(4'h0, 16'h0001);
		rd(4'h0, 16'h0001);
		chk(full_duplex, 1'b0);
		wr(4'h0, 16'h0003);
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		rd(4'h0, 16'h0000);
		chk(full_duplex, 1'b0);
		$display("reset test done");
		wr(4'h3, 16'h0010);
		k = hpick(48'h000000000001);
		ibrx_mem_i.mem[12 + k[5:4]] = 16'h0001 << k[3:0];
		wr(4'h5, 16'h0001);
		repeat (80) @(posedge clock);
		dst(48'h000000000001, 1'b1);
		dst(48'h000000000003, hpick(48'h000000000003) == k);
		dst(48'h665544332210, 1'b1);
		$display("hash test done");
		end_sim;
	end
endmodule // tb_ibrx_core
